// ==== design/lws_pkg.sv ====
/*
 Constants, register map and types for the list waveform sequencer.
 Assumes a 100 MHz system clock and an AXI4-Lite master with 32-bit data.
*/
// How it works
// RULE1: Repeat count 0..255 sets full passes
// RULE2: Repeat zero loops until stop command
// RULE3: Repeat query returns last stored count
// RULE4: Later passes skip first skip-count steps
// RULE5: List clear zeroes skip count
// RULE6: Skipping only when playing upward
// RULE7: Skip query returns last stored value
// RULE8: Each value fills next table location
// RULE9: Long lists split over several writes
// RULE10: Current access with voltage entries errors
// RULE11: Host picks function mode before values
// RULE12: Value readback window of sixteen
// RULE13: Entry pointer cleared, incremented, readable
// RULE14: Up or down direction, reset up
// RULE15: Direction query answers UP or DOWN
// RULE16: Dwell 0.0005..10 s per location
// RULE17: Single dwell entry applies everywhere
// RULE18: Dwell readback window of sixteen
// RULE19: Default order equals table location
// RULE20: Clear resets pointers, direction, count
// RULE21: Final pass ends holding last value
// RULE22: Dwell counted in microsecond ticks
// RULE23: Index wraps at each repetition
package lws_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int US_NS = 1000;
   localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [23:0] DWELL_MIN_US = 24'h00_01F4;
   localparam logic [23:0] DWELL_MAX_US = 24'h98_9680;
   // ----------------------------------------------------------------
   // Table sizes
   // ----------------------------------------------------------------
   localparam int TABLE_DEPTH = 1002;
   localparam int INPUT_BUF_CHARS = 253;
   localparam int WINDOW_WORDS = 16;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_REPEAT = 8'h04;
   localparam logic [7:0] OFF_SKIP = 8'h08;
   localparam logic [7:0] OFF_VALUE = 8'h0C;
   localparam logic [7:0] OFF_DWELL = 8'h10;
   localparam logic [7:0] OFF_VALUE_PTR = 8'h14;
   localparam logic [7:0] OFF_DWELL_PTR = 8'h18;
   localparam logic [7:0] OFF_QSTART = 8'h1C;
   localparam logic [7:0] OFF_ERROR = 8'h24;
   localparam logic [7:0] OFF_STATUS = 8'h28;
   localparam logic [7:0] OFF_SETPOINT = 8'h2C;
   localparam logic [7:0] OFF_DIR_WORD = 8'h30;
   localparam logic [1:0] WIN_MAIN = 2'h1;
   localparam logic [1:0] WIN_DWELL = 2'h2;
   // ----------------------------------------------------------------
   // Fields and values
   // ----------------------------------------------------------------
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STOP_BIT = 1;
   localparam int CTRL_CLEAR_BIT = 2;
   localparam int CTRL_DIR_BIT = 3;
   localparam int CTRL_FUNC_BIT = 4;
   localparam logic [7:0] REPEAT_RST = 8'h01;
   localparam logic [7:0] SKIP_RST = 8'h00;
   localparam logic [31:0] ERR_SETTINGS_CONFLICT = 32'hFFFF_FF23;
   localparam logic [31:0] DIR_WORD_UP = 32'h0000_5550;
   localparam logic [31:0] DIR_WORD_DOWN = 32'h444F_574E;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic dir_down;
      logic func_curr;
      logic [7:0] repeat_n;
      logic [7:0] skip_n;
   } lws_cfg_s;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } lws_state_e;
endpackage

// ==== design/lws_list_sequencer.sv ====
/*
 List waveform sequencer: setpoint and dwell tables, playback engine and
 AXI4-Lite register slave. Assumes a single clock and a well-behaved master.
*/
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module lws_list_sequencer
   import lws_pkg::*;
#(
   parameter int DEPTH = TABLE_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic [31:0] list_setpoint,
   output logic list_running
);
   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   // Pointers are ten bits wide
   if (DEPTH < 2 || DEPTH > 1023) begin : g_bad_depth
      $error("DEPTH must lie between 2 and 1023");
   end

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic [23:0] dwell_clamp(input logic [31:0] v);
      if (v < {8'h00, DWELL_MIN_US}) begin
         return DWELL_MIN_US;
      end else if (v > {8'h00, DWELL_MAX_US}) begin
         return DWELL_MAX_US;
      end
      return v[23:0];
   endfunction

   function automatic logic [23:0] dwell_pick(input logic [9:0] dptr, input logic [9:0] i,
                                              input logic [23:0] d0, input logic [23:0] di);
      if (dptr == 10'h000) begin
         return DWELL_MIN_US;
      end else if (dptr == 10'h001 || i >= dptr) begin
         return d0;
      end
      return di;
   endfunction

   function automatic logic [9:0] win_index(input logic [9:0] start, input logic [7:0] addr);
      return start + {6'h00, addr[5:2]};
   endfunction

   // ----------------------------------------------------------------
   // Storage and state
   // ----------------------------------------------------------------
   logic [31:0] main_mem [DEPTH];
   logic [23:0] dwell_mem [DEPTH];
   lws_cfg_s cfg;
   lws_state_e state;
   logic [9:0] ptr_main;
   logic [9:0] ptr_dwell;
   logic [9:0] qstart;
   logic volt_has;
   logic curr_has;
   logic [31:0] err_code;
   logic [9:0] idx;
   logic [7:0] passes;
   logic [23:0] dwell_left;
   logic [6:0] us_cnt;
   logic aw_held;
   logic [7:0] aw_addr_q;
   logic w_held;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   logic wr_fire;
   logic full_word;
   logic lane0;
   logic wr_ctrl;
   logic start_cmd;
   logic stop_cmd;
   logic clear_cmd;
   logic wr_val;
   logic conflict_wr;
   logic store_val;
   logic store_dwell;
   logic wr_mapped;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign full_word = wstrb_q == 4'hF;
   assign lane0 = wstrb_q[0];
   assign wr_ctrl = wr_fire && aw_addr_q == OFF_CTRL && lane0;
   assign start_cmd = wr_ctrl && wdata_q[CTRL_START_BIT];
   assign stop_cmd = wr_ctrl && wdata_q[CTRL_STOP_BIT];
   assign clear_cmd = wr_ctrl && wdata_q[CTRL_CLEAR_BIT];
   assign wr_val = wr_fire && aw_addr_q == OFF_VALUE && full_word;
   assign conflict_wr = wr_val && (cfg.func_curr ? volt_has : curr_has); // RULE10
   assign store_val = wr_val && !conflict_wr && ptr_main < 10'(DEPTH); // RULE8 RULE9
   assign store_dwell = wr_fire && aw_addr_q == OFF_DWELL && full_word
                        && ptr_dwell < 10'(DEPTH);
   assign wr_mapped = aw_addr_q inside {OFF_CTRL, OFF_REPEAT, OFF_SKIP, OFF_VALUE,
                                        OFF_DWELL, OFF_QSTART, OFF_ERROR};

   // ----------------------------------------------------------------
   // AXI write channels
   // ----------------------------------------------------------------
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         aw_held <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (s_axi_awvalid && !aw_held) begin
         aw_held <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         w_held <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (s_axi_wvalid && !w_held) begin
         w_held <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Configuration
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= '{dir_down: 1'b0, func_curr: 1'b0, repeat_n: REPEAT_RST, skip_n: SKIP_RST}; // RULE14
      end else begin
         if (wr_ctrl) begin
            cfg.dir_down <= wdata_q[CTRL_DIR_BIT]; // RULE14
            cfg.func_curr <= wdata_q[CTRL_FUNC_BIT]; // RULE11
         end
         if (wr_fire && aw_addr_q == OFF_REPEAT && lane0) begin
            cfg.repeat_n <= wdata_q[7:0]; // RULE1
         end
         if (wr_fire && aw_addr_q == OFF_SKIP && lane0) begin
            cfg.skip_n <= wdata_q[7:0]; // RULE4
         end
         // Clear wins over a direction written alongside it
         if (clear_cmd) begin
            cfg.dir_down <= 1'b0; // RULE20
            cfg.repeat_n <= REPEAT_RST; // RULE20
            cfg.skip_n <= SKIP_RST; // RULE5
         end
      end
   end

   // ----------------------------------------------------------------
   // Tables and pointers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (store_val) begin
         main_mem[ptr_main] <= wdata_q; // RULE19
      end
      if (store_dwell) begin
         dwell_mem[ptr_dwell] <= dwell_clamp(wdata_q); // RULE16
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ptr_main <= 10'h000;
         ptr_dwell <= 10'h000;
         volt_has <= 1'b0;
         curr_has <= 1'b0;
      end else if (clear_cmd) begin
         ptr_main <= 10'h000; // RULE13 RULE20
         ptr_dwell <= 10'h000; // RULE20
         volt_has <= 1'b0;
         curr_has <= 1'b0;
      end else begin
         if (store_val) begin
            ptr_main <= ptr_main + 10'h001; // RULE13
            volt_has <= volt_has | !cfg.func_curr;
            curr_has <= curr_has | cfg.func_curr;
         end
         if (store_dwell) begin
            ptr_dwell <= ptr_dwell + 10'h001;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         qstart <= 10'h000;
      end else if (clear_cmd) begin
         qstart <= 10'h000;
      end else if (wr_fire && aw_addr_q == OFF_QSTART && full_word) begin
         qstart <= wdata_q[9:0];
      end
   end

   // ----------------------------------------------------------------
   // Error code
   // ----------------------------------------------------------------
   logic rd_fire;
   logic rd_main_win;
   logic rd_conflict;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
   assign rd_main_win = s_axi_araddr[7:6] == WIN_MAIN;
   assign rd_conflict = rd_fire && cfg.func_curr && volt_has
                        && (rd_main_win || s_axi_araddr == OFF_VALUE_PTR); // RULE10

   // A new conflict beats a clear in the same cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         err_code <= 32'h0000_0000;
      end else if (conflict_wr || rd_conflict) begin
         err_code <= ERR_SETTINGS_CONFLICT; // RULE10
      end else if (wr_fire && aw_addr_q == OFF_ERROR) begin
         err_code <= 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Playback engine
   // ----------------------------------------------------------------
   logic run;
   logic tick;
   logic step_end;
   logic pass_end;
   logic final_end;
   logic [9:0] last_idx;
   logic [9:0] start_idx;
   logic [9:0] next_idx;
   logic start_down;
   assign run = state == ST_RUN;
   assign tick = us_cnt == 7'(US_CYCLES - 1); // RULE22
   assign step_end = run && tick && dwell_left <= 24'h00_0001; // RULE22
   assign last_idx = ptr_main - 10'h001;
   // Direction written with start must pick the first step
   assign start_down = wr_ctrl ? wdata_q[CTRL_DIR_BIT] : cfg.dir_down;
   assign start_idx = start_down ? last_idx : 10'h000; // RULE14

   always_comb begin
      pass_end = 1'b0;
      next_idx = idx;
      if (cfg.dir_down) begin
         if (idx == 10'h000) begin
            pass_end = 1'b1;
            next_idx = last_idx; // RULE6 RULE23
         end else begin
            next_idx = idx - 10'h001;
         end
      end else if (idx >= last_idx) begin
         pass_end = 1'b1;
         // A skip covering the whole list replays only the last step
         next_idx = ({2'h0, cfg.skip_n} < ptr_main) ? {2'h0, cfg.skip_n} : last_idx; // RULE4 RULE23
      end else begin
         next_idx = idx + 10'h001; // RULE19
      end
   end
   assign final_end = pass_end && cfg.repeat_n != 8'h00
                      && ({1'b0, passes} + 9'h001) >= {1'b0, cfg.repeat_n}; // RULE1 RULE2

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         us_cnt <= 7'h00;
      end else if (!run || start_cmd || tick) begin
         us_cnt <= 7'h00;
      end else begin
         us_cnt <= us_cnt + 7'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         idx <= 10'h000;
         passes <= 8'h00;
         dwell_left <= 24'h00_0000;
         list_setpoint <= 32'h0000_0000;
      end else if (clear_cmd || stop_cmd) begin
         state <= ST_IDLE; // RULE2
      end else if (start_cmd && ptr_main != 10'h000) begin
         state <= ST_RUN;
         idx <= start_idx;
         passes <= 8'h00;
         list_setpoint <= main_mem[start_idx];
         dwell_left <= dwell_pick(ptr_dwell, start_idx, dwell_mem[0],
                                  dwell_mem[start_idx]); // RULE16 RULE17
      end else if (step_end) begin
         if (final_end) begin
            state <= ST_IDLE; // RULE21
         end else begin
            idx <= next_idx;
            if (pass_end) begin
               passes <= passes + 8'h01;
            end
            list_setpoint <= main_mem[next_idx];
            dwell_left <= dwell_pick(ptr_dwell, next_idx, dwell_mem[0],
                                     dwell_mem[next_idx]); // RULE17
         end
      end else if (run && tick) begin
         dwell_left <= dwell_left - 24'h00_0001; // RULE22
      end
   end
   assign list_running = run;

   // ----------------------------------------------------------------
   // AXI read channel
   // ----------------------------------------------------------------
   logic [9:0] win_i;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   assign win_i = win_index(qstart, s_axi_araddr);

   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rresp = RESP_OKAY;
      unique case (s_axi_araddr[7:6])
         WIN_MAIN: begin
            if (win_i < ptr_main) begin
               next_rdata = main_mem[win_i]; // RULE12
            end
         end
         WIN_DWELL: begin
            if (win_i < ptr_dwell) begin
               next_rdata = {8'h00, dwell_mem[win_i]}; // RULE18
            end
         end
         2'h3: next_rresp = RESP_SLVERR;
         2'h0: begin
            unique case (s_axi_araddr)
               OFF_CTRL: next_rdata = {27'h000_0000, cfg.func_curr, cfg.dir_down, 3'h0};
               OFF_REPEAT: next_rdata = {24'h00_0000, cfg.repeat_n}; // RULE3
               OFF_SKIP: next_rdata = {24'h00_0000, cfg.skip_n}; // RULE7
               OFF_VALUE_PTR: next_rdata = {22'h00_0000, ptr_main}; // RULE13
               OFF_DWELL_PTR: next_rdata = {22'h00_0000, ptr_dwell};
               OFF_QSTART: next_rdata = {22'h00_0000, qstart};
               OFF_ERROR: next_rdata = err_code;
               OFF_STATUS: next_rdata = {16'h0000, passes, 5'h00, cfg.func_curr,
                                         cfg.dir_down, run};
               OFF_SETPOINT: next_rdata = list_setpoint;
               OFF_DIR_WORD: next_rdata = cfg.dir_down ? DIR_WORD_DOWN : DIR_WORD_UP; // RULE15
               default: next_rresp = RESP_SLVERR;
            endcase
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_clear_skip_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
      clear_cmd |=> cfg.skip_n == 8'h00 && cfg.repeat_n == REPEAT_RST && !cfg.dir_down)
      else $error("clear left skip, repeat or direction set");
   a_repeat_readback: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE3
      rd_fire && s_axi_araddr == OFF_REPEAT && !wr_fire |=> s_axi_rdata[7:0] == cfg.repeat_n)
      else $error("repeat readback mismatch");
   a_entry_ptr_step: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE13
      store_val && !clear_cmd |=> ptr_main == $past(ptr_main) + 10'h001)
      else $error("entry pointer did not advance");
   a_conflict_posts: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE10
      wr_val && cfg.func_curr && volt_has |=> err_code == ERR_SETTINGS_CONFLICT
      && ptr_main == $past(ptr_main))
      else $error("current entry with voltage list not refused");
   a_down_no_skip: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE6
      step_end && cfg.dir_down && idx == 10'h000 && !final_end && !clear_cmd && !stop_cmd
      && !start_cmd |=> idx == $past(last_idx))
      else $error("downward wrap did not restart at last entry");
   a_up_skip_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
      step_end && pass_end && !cfg.dir_down && !final_end && !clear_cmd && !stop_cmd
      && !start_cmd && {2'h0, cfg.skip_n} < ptr_main |=> idx == {2'h0, $past(cfg.skip_n)})
      else $error("upward wrap ignored skip count");
   a_final_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE21
      step_end && final_end && !start_cmd && !clear_cmd && !stop_cmd
      |=> !list_running ##1 $stable(list_setpoint))
      else $error("final pass did not stop and hold");
   a_endless_loop: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
      run && cfg.repeat_n == 8'h00 && !clear_cmd && !stop_cmd |=> run)
      else $error("endless list stopped by itself");
   a_single_dwell: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE17
      step_end && !final_end && ptr_dwell == 10'h001 && !clear_cmd && !stop_cmd
      && !start_cmd |=> dwell_left == dwell_mem[0])
      else $error("single dwell not applied to step");
   a_dir_word: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE15
      rd_fire && s_axi_araddr == OFF_DIR_WORD && !wr_fire
      |=> s_axi_rdata == (cfg.dir_down ? DIR_WORD_DOWN : DIR_WORD_UP))
      else $error("direction word wrong");
endmodule // lws_list_sequencer

// ==== bench/lws_host_model.sv ====
/*
 Host model: AXI4-Lite master that writes and reads the sequencer registers.
 Assumes the bench calls its tasks one at a time from a single process.
*/
`timescale 1ns/10ps
module lws_host_model (
   input wire logic clk_sys,
   output logic awvalid,
   output logic [7:0] awaddr,
   output logic wvalid,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic bready,
   output logic arvalid,
   output logic [7:0] araddr,
   output logic rready,
   input wire logic awready,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic arready,
   input wire logic rvalid
);
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      araddr = 8'h00;
   end
   // One value per write, so long lists go out as many writes
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk_sys);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk_sys);
         if (awvalid && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk_sys); while (bvalid !== 1'b1);
      bready <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(posedge clk_sys); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk_sys); while (rvalid !== 1'b1);
      rready <= 1'b0;
      #1;
   endtask
endmodule // lws_host_model

// ==== bench/tb.sv ====
/*
 Self-checking bench for the list sequencer, driven through the host model.
 Assumes one 100 MHz clock; playback steps use the 500 us minimum dwell.
*/
`timescale 1ns/10ps
module tb;
   import lws_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, running;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdat, setpoint;
   logic [3:0] ws;
   logic [1:0] bresp, rresp;
   logic [33:0] bq[$], rq[$];
   int fails = 0;
   int checks_done = 0;
   int cyc = 0;
   always #5 clk_sys = ~clk_sys;
   lws_list_sequencer i_lws_list_sequencer (.clk_sys(clk_sys), .rst_n(rst_n),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
      .s_axi_wready(wr_), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat),
      .s_axi_rresp(rresp), .list_setpoint(setpoint), .list_running(running));
   lws_host_model i_lws_host_model (.clk_sys(clk_sys), .awvalid(awv), .awaddr(awa),
      .wvalid(wv), .wdata(wd), .wstrb(ws), .bready(br), .arvalid(arv), .araddr(ara),
      .rready(rr), .awready(awr), .wready(wr_), .bvalid(bv), .arready(arr), .rvalid(rv));
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bq.push_back({r, 32'h0});
      i_lws_host_model.wr(a, d);
   endtask
   task automatic r(input logic [7:0] a, input logic [31:0] e);
      rq.push_back({RESP_OKAY, e});
      i_lws_host_model.rd(a);
   endtask
   // ----------------------------------------------------------------
   // Response watcher and hang guard
   // ----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (bv === 1'b1 && br && bq.size() > 0)
         check({bresp, 32'h0}, bq.pop_front());
      if (rv === 1'b1 && rr && rq.size() > 0)
         check({rresp, rdat}, rq.pop_front());
      cyc <= cyc + 1;
      if (cyc == 70000) begin
         fails++;
         tally_and_finish();
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] v[3];
      int n;
      void'($urandom(32'hc0288d8b));
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      r(OFF_REPEAT, 32'h1);
      r(OFF_DIR_WORD, DIR_WORD_UP);
      r(OFF_VALUE_PTR, 32'h0);
      v[0] = $urandom & 32'hFF;
      v[1] = $urandom & 32'hFF;
      w(OFF_REPEAT, v[0], RESP_OKAY);
      r(OFF_REPEAT, v[0]);
      w(OFF_SKIP, v[1], RESP_OKAY);
      r(OFF_SKIP, v[1]);
      w(OFF_CTRL, 32'h8, RESP_OKAY);
      r(OFF_DIR_WORD, DIR_WORD_DOWN);
      w(OFF_CTRL, 32'h4, RESP_OKAY);
      r(OFF_DIR_WORD, DIR_WORD_UP);
      r(OFF_REPEAT, 32'h1);
      r(OFF_SKIP, 32'h0);
      // Current mode goes first, the values follow
      w(OFF_CTRL, 32'h10, RESP_OKAY);
      for (n = 0; n < 3; n++) begin
         v[n] = $urandom;
         w(OFF_VALUE, v[n], RESP_OKAY);
      end
      r(OFF_VALUE_PTR, 32'h3);
      for (n = 0; n < 3; n++)
         r(8'h40 + 8'(4 * n), v[n]);
      r(8'h4C, 32'h0);
      w(OFF_CTRL, 32'h19, RESP_OKAY);
      check({2'h0, setpoint}, {2'h0, v[2]});
      w(OFF_CTRL, 32'h12, RESP_OKAY);
      w(OFF_DWELL, 32'h0, RESP_OKAY);
      r(8'h80, 32'h1F4);
      r(OFF_DWELL_PTR, 32'h1);
      w(OFF_QSTART, 32'h1, RESP_OKAY);
      r(8'h40, v[1]);
      r(8'h80, 32'h0);
      w(8'h20, 32'h0, RESP_SLVERR);
      w(OFF_CTRL, 32'h4, RESP_OKAY);
      w(OFF_CTRL, 32'h0, RESP_OKAY);
      v[0] = $urandom;
      w(OFF_VALUE, v[0], RESP_OKAY);
      w(OFF_CTRL, 32'h10, RESP_OKAY);
      w(OFF_VALUE, $urandom, RESP_OKAY);
      r(OFF_ERROR, ERR_SETTINGS_CONFLICT);
      w(OFF_ERROR, 32'h0, RESP_OKAY);
      r(OFF_ERROR, 32'h0);
      r(OFF_VALUE_PTR, 32'h1);
      r(OFF_ERROR, ERR_SETTINGS_CONFLICT);
      w(OFF_CTRL, 32'h0, RESP_OKAY);
      w(OFF_REPEAT, 32'h0, RESP_OKAY);
      w(OFF_CTRL, 32'h1, RESP_OKAY);
      check({2'h0, setpoint}, {2'h0, v[0]});
      check({33'h0, running}, 34'h1);
      r(OFF_STATUS, 32'h1);
      r(OFF_SETPOINT, v[0]);
      w(OFF_CTRL, 32'h2, RESP_OKAY);
      check({33'h0, running}, 34'h0);
      w(OFF_REPEAT, 32'h1, RESP_OKAY);
      w(OFF_CTRL, 32'h1, RESP_OKAY);
      // Single step of the 500 us default dwell; bounded wait
      n = 0;
      while (running === 1'b1 && n < 60000) begin
         @(posedge clk_sys);
         n++;
      end
      check({2'h0, 32'(n > 49900 && n < 50100)}, 34'h1);
      check({2'h0, setpoint}, {2'h0, v[0]});
      tally_and_finish();
   end
endmodule // tb
